// ### core/clc_pkg.sv
// Package for the charge limit control register bank.
// Assumes a 10 MHz core clock and a byte-wide register port.
package clc_pkg;

   // ----
   // Register offsets and reset values
   // ----
   localparam logic [7:0] OFS_PRECHG_TERM = 8'h03;
   localparam logic [7:0] OFS_VOLT_LIMIT = 8'h04;
   localparam logic [7:0] OFS_CTRL_SECOND = 8'h05;
   localparam logic [7:0] RST_PRECHG_TERM = 8'h22;
   localparam logic [7:0] RST_VOLT_LIMIT = 8'h58;
   localparam logic [7:0] RST_CTRL_SECOND = 8'h9F;

   // ----
   // Field positions
   // ----
   localparam int PRECHG_LSB = 4;
   localparam int TERM_LSB = 0;
   localparam int VOLT_LSB = 3;
   localparam int TOPOFF_LSB = 1;
   localparam int RECHG_BIT = 0;
   localparam int TERM_EN_BIT = 7;
   localparam int SHARED_BIT = 6;
   localparam int WDOG_LSB = 4;
   localparam int TIMER_EN_BIT = 3;
   localparam int TIMER_LEN_BIT = 2;
   localparam int THERM_BIT = 1;
   localparam int COLD_BIT = 0;

   // ----
   // Decode constants
   // ----
   localparam logic [3:0] PRECHG_MAX_CODE = 4'hC;
   localparam logic [4:0] VOLT_MAX_CODE = 5'h18;
   localparam logic [4:0] VOLT_SPECIAL_CODE = 5'h0F;
   localparam logic [11:0] CUR_STEP_MA = 12'h03C;
   localparam logic [12:0] VOLT_BASE_MV = 13'hF10;
   localparam logic [12:0] VOLT_STEP_MV = 13'h020;
   localparam logic [12:0] VOLT_SPECIAL_MV = 13'h1100;
   localparam logic [12:0] RECHG_HIGH_MV = 13'h00C8;
   localparam logic [12:0] RECHG_LOW_MV = 13'h0064;
   localparam logic [7:0] THERM_LOW_C = 8'h50;
   localparam logic [7:0] THERM_HIGH_C = 8'h78;
   localparam logic [6:0] COLD_PCT_LOW = 7'h32;
   localparam logic [6:0] COLD_PCT_HIGH = 7'h14;

   // ----
   // Timing
   // ----
   localparam longint CLK_HZ = 10000000;
   localparam longint WDOG_BASE_S = 40;
   localparam longint WDOG_BASE_CYC = WDOG_BASE_S * CLK_HZ;
   localparam longint DGL_LONG_MS = 230;
   localparam longint DGL_SHORT_MS = 16;
   localparam longint DGL_LONG_CYC = DGL_LONG_MS * CLK_HZ / 1000;
   localparam longint DGL_SHORT_CYC = DGL_SHORT_MS * CLK_HZ / 1000;
   localparam longint TIMER_SHORT_H = 7;
   localparam longint TIMER_LONG_H = 16;
   localparam longint TIMER_SHORT_CYC = TIMER_SHORT_H * 3600 * CLK_HZ;
   localparam longint TIMER_LONG_CYC = TIMER_LONG_H * 3600 * CLK_HZ;

   // ----
   // Carriers
   // ----
   typedef struct packed {
      logic [11:0] precharge_ma;
      logic [11:0] term_ma;
      logic [12:0] charge_mv;
      logic [12:0] recharge_mv;
      logic [7:0] therm_c;
      logic [6:0] cold_pct;
   } clc_setpoint_s;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } clc_reg_req_s;

   typedef enum logic [3:0] {
      CHG_IDLE = 4'h1,
      CHG_RUN = 4'h2,
      CHG_TOPOFF = 4'h4,
      CHG_DONE = 4'h8
   } clc_chg_e;

endpackage

// ### core/clc_down_counter.sv
// Loadable down counter with terminal pulse.
// Assumes synchronous load and a shared clock enable.
module clc_down_counter #(
   parameter int WIDTH = 40
) (
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire logic clk_en_in,
   input wire logic load_in,
   input wire logic [WIDTH-1:0] load_val_in,
   input wire logic run_in,
   output logic expire_out
);

   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] next_count;
   logic next_expire;

   always_comb
   begin
      next_count = count;
      next_expire = 1'b0;
      if (load_in)
      begin
         next_count = load_val_in;
      end
      else if (run_in && count != '0)
      begin
         next_count = count - 1'b1;
         next_expire = (count == {{(WIDTH-1){1'b0}}, 1'b1});
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         count <= '0;
         expire_out <= 1'b0;
      end
      else if (clk_en_in)
      begin
         count <= next_count;
         expire_out <= next_expire;
      end
   end

endmodule

// ### core/clc_regs.sv
// Charge limit control registers, decoders, watchdog and charge sequencing.
// Assumes the serial bus slave outside presents single-cycle byte
// requests on the core clock; charger events arrive synchronised.

// Overview of operation
// - Pre-charge current is 60mA plus 60mA per code; default code 0010.
// - Pre-charge codes above 1100 act as 1100.
// - Termination current is 60mA plus 60mA per code; default 0010.
// - Charge voltage is 3856mV plus 32mV per code; default 01011.
// - Charge voltage code 01111 gives fixed 4352mV.
// - Charge voltage codes above 11000 act as 11000.
// - Recharge starts when battery drops by selected offset; set is 200mV.
// - Top-off 00 ends at termination; others add a top-off interval.
// - Termination happens only while termination enable is set.
// - Over-current clears direct charge enable only when shared bit is 0.
// - With direct charge off, shared bit picks 230ms or 16ms deglitch.
// - Watchdog expires at 40, 80 or 160s; code 00 disables it.
// - Safety timer covers pre-charge and fast charge when enabled.
// - Safety timer is 7h when bit clear, 16h when set.
// - Thermal regulation starts at 80C or 120C by threshold bit.
// - Cold-zone scaling cuts current to 50% or 20%.
module clc_regs #(
   parameter longint WDOG_BASE_CYCLES = clc_pkg::WDOG_BASE_CYC,
   parameter longint DGL_LONG_CYCLES = clc_pkg::DGL_LONG_CYC,
   parameter longint DGL_SHORT_CYCLES = clc_pkg::DGL_SHORT_CYC,
   parameter longint TIMER_SHORT_CYCLES = clc_pkg::TIMER_SHORT_CYC,
   parameter longint TIMER_LONG_CYCLES = clc_pkg::TIMER_LONG_CYC,
   parameter longint TOPOFF_UNIT_CYCLES = 64'd100
) (
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire logic clk_en_in,
   input wire clc_pkg::clc_reg_req_s req_in,
   input wire logic reg_reset_in,
   input wire logic wdog_kick_in,
   input wire logic charge_start_in,
   input wire logic term_cond_in,
   input wire logic recharge_cond_in,
   input wire logic input_overcurrent_in,
   input wire logic direct_charge_set_in,
   input wire logic cold_zone_in,
   output logic [7:0] rdata_out,
   output clc_pkg::clc_setpoint_s setpoint_out,
   output logic direct_charge_enable_out,
   output logic wdog_expired_out,
   output logic charging_out,
   output logic safety_fault_out,
   output logic charge_done_out,
   output logic cold_scale_active_out
);

   // ----
   // Register state
   // ----
   logic [7:0] precharge_and_termination_current;
   logic [7:0] battery_voltage_limit;
   logic [7:0] charge_control_second;
   logic [7:0] next_prechg_term;
   logic [7:0] next_volt_limit;
   logic [7:0] next_ctrl_second;
   logic [7:0] next_rdata;
   logic wdog_expire;
   logic defaults;

   assign defaults = reg_reset_in | wdog_expire;

   always_comb
   begin
      next_prechg_term = precharge_and_termination_current;
      next_volt_limit = battery_voltage_limit;
      next_ctrl_second = charge_control_second;
      next_rdata = rdata_out;
      if (defaults)
      begin
         next_prechg_term = clc_pkg::RST_PRECHG_TERM;
         next_volt_limit = clc_pkg::RST_VOLT_LIMIT;
         next_ctrl_second = clc_pkg::RST_CTRL_SECOND;
      end
      else if (req_in.wr)
      begin
         unique case (req_in.addr)
            clc_pkg::OFS_PRECHG_TERM: next_prechg_term = req_in.wdata;
            clc_pkg::OFS_VOLT_LIMIT: next_volt_limit = req_in.wdata;
            clc_pkg::OFS_CTRL_SECOND: next_ctrl_second = req_in.wdata;
            default: ;
         endcase
      end
      if (req_in.rd)
      begin
         unique case (req_in.addr)
            clc_pkg::OFS_PRECHG_TERM:
               next_rdata = precharge_and_termination_current;
            clc_pkg::OFS_VOLT_LIMIT: next_rdata = battery_voltage_limit;
            clc_pkg::OFS_CTRL_SECOND: next_rdata = charge_control_second;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         precharge_and_termination_current <= clc_pkg::RST_PRECHG_TERM;
         battery_voltage_limit <= clc_pkg::RST_VOLT_LIMIT;
         charge_control_second <= clc_pkg::RST_CTRL_SECOND;
         rdata_out <= 8'h00;
      end
      else if (clk_en_in)
      begin
         precharge_and_termination_current <= next_prechg_term;
         battery_voltage_limit <= next_volt_limit;
         charge_control_second <= next_ctrl_second;
         rdata_out <= next_rdata;
      end
   end

   // ----
   // Field views
   // ----
   logic [3:0] precharge_current_code;
   logic [3:0] termination_current_code;
   logic [4:0] charge_voltage_code;
   logic [1:0] topoff_interval_select;
   logic recharge_offset_select;
   logic term_enable;
   logic direct_reset_or_deglitch_select;
   logic [1:0] wdog_select;
   logic timer_enable;
   logic safety_timer_length;
   logic thermal_regulation_threshold;
   logic cold_zone_current_scale;

   assign precharge_current_code =
      precharge_and_termination_current[clc_pkg::PRECHG_LSB +: 4];
   assign termination_current_code =
      precharge_and_termination_current[clc_pkg::TERM_LSB +: 4];
   assign charge_voltage_code = battery_voltage_limit[clc_pkg::VOLT_LSB +: 5];
   assign topoff_interval_select =
      battery_voltage_limit[clc_pkg::TOPOFF_LSB +: 2];
   assign recharge_offset_select = battery_voltage_limit[clc_pkg::RECHG_BIT];
   assign term_enable = charge_control_second[clc_pkg::TERM_EN_BIT];
   assign direct_reset_or_deglitch_select =
      charge_control_second[clc_pkg::SHARED_BIT];
   assign wdog_select = charge_control_second[clc_pkg::WDOG_LSB +: 2];
   assign timer_enable = charge_control_second[clc_pkg::TIMER_EN_BIT];
   assign safety_timer_length = charge_control_second[clc_pkg::TIMER_LEN_BIT];
   assign thermal_regulation_threshold =
      charge_control_second[clc_pkg::THERM_BIT];
   assign cold_zone_current_scale = charge_control_second[clc_pkg::COLD_BIT];

   // ----
   // Decoders
   // ----
   // Both current fields share one step, so one decoder serves both
   function automatic logic [11:0] cur_ma(input logic [3:0] code);
      cur_ma = clc_pkg::CUR_STEP_MA + 12'(code) * clc_pkg::CUR_STEP_MA;
   endfunction

   function automatic logic [12:0] volt_mv(input logic [4:0] code);
      logic [4:0] c;
      c = (code > clc_pkg::VOLT_MAX_CODE) ? clc_pkg::VOLT_MAX_CODE : code;
      if (c == clc_pkg::VOLT_SPECIAL_CODE)
         volt_mv = clc_pkg::VOLT_SPECIAL_MV;
      else
         volt_mv = clc_pkg::VOLT_BASE_MV + 13'(c) * clc_pkg::VOLT_STEP_MV;
   endfunction

   clc_pkg::clc_setpoint_s next_setpoint;
   logic [3:0] prechg_clamped;

   always_comb
   begin
      prechg_clamped = (precharge_current_code > clc_pkg::PRECHG_MAX_CODE) ?
         clc_pkg::PRECHG_MAX_CODE : precharge_current_code;
      next_setpoint.precharge_ma = cur_ma(prechg_clamped);
      next_setpoint.term_ma = cur_ma(termination_current_code);
      next_setpoint.charge_mv = volt_mv(charge_voltage_code);
      next_setpoint.recharge_mv = recharge_offset_select ?
         clc_pkg::RECHG_HIGH_MV : clc_pkg::RECHG_LOW_MV;
      next_setpoint.therm_c = thermal_regulation_threshold ?
         clc_pkg::THERM_HIGH_C : clc_pkg::THERM_LOW_C;
      next_setpoint.cold_pct = cold_zone_current_scale ?
         clc_pkg::COLD_PCT_HIGH : clc_pkg::COLD_PCT_LOW;
   end

   // ----
   // Watchdog
   // ----
   logic wdog_load;
   logic [39:0] wdog_len;

   // Any write counts as host activity, as does an explicit kick
   assign wdog_load = wdog_kick_in | req_in.wr | reg_reset_in |
      wdog_expire;

   always_comb
   begin
      unique case (wdog_select)
         2'b01: wdog_len = 40'(WDOG_BASE_CYCLES);
         2'b10: wdog_len = 40'(WDOG_BASE_CYCLES * 2);
         2'b11: wdog_len = 40'(WDOG_BASE_CYCLES * 4);
         default: wdog_len = 40'h0;
      endcase
   end

   clc_down_counter #(.WIDTH(40)) u_wdog (
      .ref_clk_in(ref_clk_in),
      .arst_n_in(arst_n_in),
      .clk_en_in(clk_en_in),
      .load_in(wdog_load),
      .load_val_in(wdog_len),
      .run_in(wdog_select != 2'b00),
      .expire_out(wdog_expire)
   );

   // ----
   // Charge sequencing, safety timer, deglitch, direct charge
   // ----
   clc_pkg::clc_chg_e state;
   clc_pkg::clc_chg_e next_state;
   logic [39:0] safety_cnt;
   logic [39:0] next_safety_cnt;
   logic [27:0] dgl_cnt;
   logic [27:0] next_dgl_cnt;
   logic [27:0] topoff_cnt;
   logic [27:0] next_topoff_cnt;
   logic next_fault;
   logic next_dc;
   logic [27:0] dgl_len;
   logic [39:0] safety_len;
   logic term_ok;

   always_comb
   begin
      dgl_len = direct_reset_or_deglitch_select ?
         28'(DGL_SHORT_CYCLES) : 28'(DGL_LONG_CYCLES);
      safety_len = safety_timer_length ?
         40'(TIMER_LONG_CYCLES) : 40'(TIMER_SHORT_CYCLES);
      term_ok = (dgl_cnt >= dgl_len);
      next_state = state;
      next_safety_cnt = safety_cnt;
      next_dgl_cnt = dgl_cnt;
      next_topoff_cnt = topoff_cnt;
      next_fault = safety_fault_out;
      next_dc = direct_charge_enable_out;
      if (direct_charge_set_in)
         next_dc = 1'b1;
      else if (direct_charge_enable_out && input_overcurrent_in &&
         !direct_reset_or_deglitch_select)
         next_dc = 1'b0;
      if (term_cond_in && term_enable && !direct_charge_enable_out)
      begin
         if (!term_ok)
            next_dgl_cnt = dgl_cnt + 28'h0000001;
      end
      else
         next_dgl_cnt = 28'h0000000;
      unique case (state)
         clc_pkg::CHG_IDLE:
         begin
            if (charge_start_in)
            begin
               next_state = clc_pkg::CHG_RUN;
               next_safety_cnt = 40'h0;
               next_fault = 1'b0;
            end
         end
         clc_pkg::CHG_RUN:
         begin
            if (timer_enable)
               next_safety_cnt = safety_cnt + 40'h1;
            if (timer_enable && safety_cnt >= safety_len)
            begin
               next_fault = 1'b1;
               next_state = clc_pkg::CHG_IDLE;
            end
            else if (term_ok && term_enable)
            begin
               next_dgl_cnt = 28'h0000000;
               if (topoff_interval_select == 2'b00)
                  next_state = clc_pkg::CHG_DONE;
               else
               begin
                  next_topoff_cnt = 28'(TOPOFF_UNIT_CYCLES) *
                     28'(topoff_interval_select);
                  next_state = clc_pkg::CHG_TOPOFF;
               end
            end
         end
         clc_pkg::CHG_TOPOFF:
         begin
            next_topoff_cnt = topoff_cnt - 28'h0000001;
            if (topoff_cnt <= 28'h0000001)
               next_state = clc_pkg::CHG_DONE;
         end
         clc_pkg::CHG_DONE:
         begin
            if (recharge_cond_in)
            begin
               next_state = clc_pkg::CHG_RUN;
               next_safety_cnt = 40'h0;
            end
         end
         default: next_state = clc_pkg::CHG_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         state <= clc_pkg::CHG_IDLE;
         safety_cnt <= 40'h0;
         dgl_cnt <= 28'h0000000;
         topoff_cnt <= 28'h0000000;
         safety_fault_out <= 1'b0;
         direct_charge_enable_out <= 1'b0;
         setpoint_out <= '0;
         wdog_expired_out <= 1'b0;
         charging_out <= 1'b0;
         charge_done_out <= 1'b0;
         cold_scale_active_out <= 1'b0;
      end
      else if (clk_en_in)
      begin
         state <= next_state;
         safety_cnt <= next_safety_cnt;
         dgl_cnt <= next_dgl_cnt;
         topoff_cnt <= next_topoff_cnt;
         safety_fault_out <= next_fault;
         direct_charge_enable_out <= next_dc;
         setpoint_out <= next_setpoint;
         wdog_expired_out <= wdog_expire;
         charging_out <= (next_state == clc_pkg::CHG_RUN) ||
            (next_state == clc_pkg::CHG_TOPOFF);
         charge_done_out <= (next_state == clc_pkg::CHG_DONE);
         cold_scale_active_out <= cold_zone_in;
      end
   end

endmodule

// ### sim/clc_regs_chk.sv
// Assertion checker for the charge limit control register bank.
// Assumes binding to clc_regs and sees only its ports.
module clc_regs_chk #(
   parameter longint WDOG_BASE_CYCLES = 50
) (
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire logic clk_en_in,
   input wire clc_pkg::clc_reg_req_s req_in,
   input wire logic reg_reset_in,
   input wire logic wdog_kick_in,
   input wire logic charge_start_in,
   input wire clc_pkg::clc_setpoint_s setpoint_out,
   input wire logic wdog_expired_out,
   input wire logic charging_out,
   input wire logic charge_done_out
);
   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   default clocking dcb @(posedge ref_clk_in); endclocking
   default disable iff (!arst_n_in);
   logic wr_ok;
   logic [31:0] idle_cnt;
   logic [31:0] next_idle_cnt;
   assign wr_ok = req_in.wr && clk_en_in && !reg_reset_in;
   // Frozen while clock enable is low, like the bank itself
   always_comb
   begin
      next_idle_cnt = idle_cnt;
      if (clk_en_in)
         next_idle_cnt = (req_in.wr || wdog_kick_in || wdog_expired_out) ?
            32'h0 : idle_cnt + 32'h1;
   end
   always_ff @(posedge ref_clk_in or negedge arst_n_in)
      if (!arst_n_in)
         idle_cnt <= 32'h0;
      else
         idle_cnt <= next_idle_cnt;
   function automatic logic [11:0] cur_ma(input logic [3:0] c,
      input logic [3:0] lim);
      return 12'h03C + 12'h03C * {8'h00, (c > lim) ? lim : c};
   endfunction
   function automatic logic [12:0] volt_mv(input logic [4:0] c);
      if (c == 5'h0F)
         return 13'h1100;
      return 13'h0F10 + 13'h0020 * {8'h00, (c > 5'h18) ? 5'h18 : c};
   endfunction
   // ---------------------------------------------
   // Properties
   // ---------------------------------------------
   property p_prechg;
      wr_ok && req_in.addr == 8'h03 |-> ##2 setpoint_out.precharge_ma ==
         cur_ma($past(req_in.wdata[7:4], 2), 4'hC);
   endproperty
   a_prechg: assert property (p_prechg)
      else $error("precharge current decode wrong");
   property p_term;
      wr_ok && req_in.addr == 8'h03 |-> ##2 setpoint_out.term_ma ==
         cur_ma($past(req_in.wdata[3:0], 2), 4'hF);
   endproperty
   a_term: assert property (p_term)
      else $error("termination current decode wrong");
   property p_volt;
      wr_ok && req_in.addr == 8'h04 |-> ##2
         setpoint_out.charge_mv == volt_mv($past(req_in.wdata[7:3], 2));
   endproperty
   a_volt: assert property (p_volt)
      else $error("charge voltage decode wrong");
   property p_rechg;
      wr_ok && req_in.addr == 8'h04 |-> ##2 setpoint_out.recharge_mv ==
         ($past(req_in.wdata[0], 2) ? 13'h00C8 : 13'h0064);
   endproperty
   a_rechg: assert property (p_rechg)
      else $error("recharge offset wrong");
   property p_ctrl;
      wr_ok && req_in.addr == 8'h05 |-> ##2
         setpoint_out.therm_c == ($past(req_in.wdata[1], 2) ? 8'h78 : 8'h50)
         && setpoint_out.cold_pct ==
         ($past(req_in.wdata[0], 2) ? 7'h14 : 7'h32);
   endproperty
   a_ctrl: assert property (p_ctrl)
      else $error("thermal or cold scale decode wrong");
   property p_rst;
      reg_reset_in && clk_en_in ##1 !req_in.wr |-> ##1 setpoint_out ==
         {12'h0B4, 12'h0B4, 13'h1070, 13'h0064, 8'h78, 7'h14};
   endproperty
   a_rst: assert property (p_rst)
      else $error("register reset did not restore defaults");
   property p_wdog;
      wdog_expired_out |-> idle_cnt >= WDOG_BASE_CYCLES - 3;
   endproperty
   a_wdog: assert property (p_wdog)
      else $error("watchdog expired too early");
   property p_start;
      charge_start_in && clk_en_in && !charging_out && !charge_done_out
         |=> charging_out;
   endproperty
   a_start: assert property (p_start)
      else $error("charge start not taken");
endmodule

bind clc_regs clc_regs_chk #(.WDOG_BASE_CYCLES(WDOG_BASE_CYCLES)) u_chk (
   .ref_clk_in(ref_clk_in),
   .arst_n_in(arst_n_in),
   .clk_en_in(clk_en_in),
   .req_in(req_in),
   .reg_reset_in(reg_reset_in),
   .wdog_kick_in(wdog_kick_in),
   .charge_start_in(charge_start_in),
   .setpoint_out(setpoint_out),
   .wdog_expired_out(wdog_expired_out),
   .charging_out(charging_out),
   .charge_done_out(charge_done_out)
);

// ### sim/clc_host_model.sv
// Host model: single-byte register requests and watchdog kicks.
// Assumes the bank samples on rising edges; drives on falling ones.
module clc_host_model (
   input wire logic ref_clk_in,
   input wire logic [7:0] rdata_in,
   output clc_pkg::clc_reg_req_s req_out,
   output logic wdog_kick_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      req_out = '0;
      wdog_kick_out = 1'b0;
   end
   // Idle bus shows inverted leftovers so stale values never pass
   task automatic idle();
      req_out = '{1'b0, 1'b0, ~req_out.addr, ~req_out.wdata};
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk_in);
      req_out = '{1'b1, 1'b0, a, d};
      @(negedge ref_clk_in);
      idle();
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge ref_clk_in);
      req_out = '{1'b0, 1'b1, a, ~req_out.wdata};
      @(negedge ref_clk_in);
      idle();
      @(negedge ref_clk_in);
      d = rdata_in;
   endtask
   task automatic kick();
      @(negedge ref_clk_in);
      wdog_kick_out = 1'b1;
      @(negedge ref_clk_in);
      wdog_kick_out = 1'b0;
   endtask
endmodule

// ### sim/clc_regs_tb.sv
// Self-checking bench for the charge limit control register bank.
// Assumes shortened watchdog, deglitch and safety timer parameters.
module clc_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk_in, arst_n_in, clk_en_in, reg_reset, kick, start, term;
   logic rechg, ovc, dset, cold, dce, wexp, chg, fault, done, cold_act;
   logic [7:0] rdata;
   clc_pkg::clc_reg_req_s req;
   clc_pkg::clc_setpoint_s sp;
   int bad_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   clc_host_model host (.ref_clk_in(ref_clk_in), .rdata_in(rdata),
      .req_out(req), .wdog_kick_out(kick));
   clc_regs #(.WDOG_BASE_CYCLES(50), .DGL_LONG_CYCLES(20),
      .DGL_SHORT_CYCLES(5), .TIMER_SHORT_CYCLES(200),
      .TIMER_LONG_CYCLES(400)) DUT (
      .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
      .clk_en_in(clk_en_in), .req_in(req), .reg_reset_in(reg_reset),
      .wdog_kick_in(kick), .charge_start_in(start), .term_cond_in(term),
      .recharge_cond_in(rechg), .input_overcurrent_in(ovc),
      .direct_charge_set_in(dset), .cold_zone_in(cold),
      .rdata_out(rdata), .setpoint_out(sp),
      .direct_charge_enable_out(dce), .wdog_expired_out(wexp),
      .charging_out(chg), .safety_fault_out(fault),
      .charge_done_out(done), .cold_scale_active_out(cold_act));
   // ---------------------------------------------
   // Common tasks
   // ---------------------------------------------
   task automatic give_verdict();
      if (bad_count == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
      input string what);
      cmp_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host.rd(a, d);
      chk(16'(d), 16'(exp), "read data");
   endtask
   task automatic do_reset();
      arst_n_in = 1'b0;
      repeat (12) @(negedge ref_clk_in);
      arst_n_in = 1'b1;
   endtask
   task automatic pulse(ref logic s);
      @(negedge ref_clk_in);
      s = 1'b1;
      @(negedge ref_clk_in);
      s = 1'b0;
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_defaults();
      rd_chk(8'h03, 8'h22);
      rd_chk(8'h04, 8'h58);
      rd_chk(8'h05, 8'h9F);
      chk(16'(sp.charge_mv), 16'h1070, "default voltage");
      chk(16'(sp.precharge_ma), 16'h00B4, "default precharge");
      host.wr(8'h06, 8'hFF);
      rd_chk(8'h06, 8'h00);
   endtask
   task automatic t_currents();
      for (int c = 0; c < 16; c++)
      begin
         host.wr(8'h03, {4'(c), ~4'(c)});
         @(negedge ref_clk_in);
         chk(16'(sp.precharge_ma), 16'(60 + 60 * (c > 12 ? 12 : c)),
            "precharge");
         chk(16'(sp.term_ma), 16'(60 + 60 * (15 - c)), "term");
      end
   endtask
   task automatic t_voltage();
      for (int c = 0; c < 32; c++)
      begin
         host.wr(8'h04, {5'(c), 2'h0, c[0]});
         @(negedge ref_clk_in);
         chk(16'(sp.charge_mv), 16'(c == 15 ? 4352 :
            3856 + 32 * (c > 24 ? 24 : c)), "voltage");
         chk(16'(sp.recharge_mv), 16'(c[0] ? 200 : 100), "recharge");
         rd_chk(8'h04, {5'(c), 2'h0, c[0]});
      end
   endtask
   task automatic t_ctrl2();
      for (int b = 0; b < 4; b++)
      begin
         host.wr(8'h05, {6'h27, 2'(b)});
         @(negedge ref_clk_in);
         chk(16'(sp.therm_c), 16'(b[1] ? 120 : 80), "thermal");
         chk(16'(sp.cold_pct), 16'(b[0] ? 20 : 50), "cold pct");
      end
      cold = 1'b1;
      repeat (2) @(negedge ref_clk_in);
      chk(16'(cold_act), 16'h1, "cold active");
      cold = 1'b0;
   endtask
   task automatic t_reg_reset();
      host.wr(8'h03, 8'hFF);
      host.wr(8'h05, 8'h00);
      pulse(reg_reset);
      rd_chk(8'h03, 8'h22);
      rd_chk(8'h05, 8'h9F);
   endtask
   task automatic t_freeze();
      host.wr(8'h05, 8'h8F);
      clk_en_in = 1'b0;
      host.wr(8'h03, 8'h55);
      pulse(dset);
      clk_en_in = 1'b1;
      rd_chk(8'h03, 8'h22);
      chk(16'(dce), 16'h0, "frozen");
   endtask
   task automatic t_wdog();
      int n;
      for (int code = 1; code < 4; code++)
      begin
         host.wr(8'h04, 8'h00);
         host.wr(8'h05, {2'h2, 2'(code), 4'hF});
         repeat (20) @(negedge ref_clk_in);
         host.kick();
         n = 0;
         while (wexp !== 1'b1 && n < 400)
         begin
            @(negedge ref_clk_in);
            n++;
         end
         chk(16'(n > 50 * (1 << (code - 1)) - 4 &&
            n < 50 * (1 << (code - 1)) + 4), 16'h1, "wdog period");
         rd_chk(8'h04, 8'h58);
      end
      host.wr(8'h05, 8'h8F);
      n = 0;
      repeat (300) @(negedge ref_clk_in) n += int'(wexp === 1'b1);
      chk(16'(n), 16'h0, "wdog disabled");
   endtask
   task automatic t_direct();
      pulse(dset);
      chk(16'(dce), 16'h1, "direct set");
      ovc = 1'b1;
      repeat (2) @(negedge ref_clk_in);
      chk(16'(dce), 16'h0, "direct cleared");
      ovc = 1'b0;
      host.wr(8'h05, 8'hCF);
      pulse(dset);
      ovc = 1'b1;
      repeat (3) @(negedge ref_clk_in);
      chk(16'(dce), 16'h1, "direct kept");
      ovc = 1'b0;
   endtask
   task automatic t_charge();
      logic [7:0] c5[7] = '{8'h8F, 8'hCF, 8'h8F, 8'h8F, 8'h0F, 8'h0B, 8'h07};
      logic [7:0] c4[7] = '{8'h58, 8'h58, 8'h5A, 8'h5E, 8'h58, 8'h58, 8'h58};
      int lo[7] = '{18, 3, 118, 318, 390, 190, 900};
      int hi[7] = '{24, 9, 124, 324, 404, 204, 900};
      logic [1:0] df[7] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h0};
      int n;
      for (int i = 0; i < 7; i++)
      begin
         do_reset();
         host.wr(8'h05, c5[i]);
         host.wr(8'h04, c4[i]);
         pulse(start);
         chk(16'(chg), 16'h1, "charging");
         term = 1'b1;
         n = 0;
         while (done !== 1'b1 && fault !== 1'b1 && n < 900)
         begin
            @(negedge ref_clk_in);
            n++;
         end
         term = 1'b0;
         chk(16'(n >= lo[i] && n <= hi[i]), 16'h1, "end time");
         chk(16'({done, fault}), 16'(df[i]), "end kind");
         if (i == 0)
         begin
            rechg = 1'b1;
            repeat (3) @(negedge ref_clk_in);
            chk(16'(chg), 16'h1, "recharge");
            rechg = 1'b0;
         end
      end
   endtask
   // ---------------------------------------------
   // Run
   // ---------------------------------------------
   initial
   begin
      ref_clk_in = 1'b0;
      forever #50 ref_clk_in = ~ref_clk_in;
   end
   always @(posedge ref_clk_in)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         bad_count++;
         give_verdict();
      end
   end
   initial
   begin
      {clk_en_in, reg_reset, start, term, rechg, ovc, dset, cold} = 8'h80;
      do_reset();
      t_defaults();
      t_currents();
      t_voltage();
      t_ctrl2();
      t_reg_reset();
      t_freeze();
      t_wdog();
      t_direct();
      t_charge();
      give_verdict();
   end
endmodule
